/* hdl/sscc_device.sv */
// Device end: trigger capture, conversion timing, busy, output register.
// Assumes analog samples arrive as signed millivolts on the user side.
`timescale 1ns/10ps
module sscc_device (
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    sscc_if.device link,
    input wire logic signed [15:0] ain_mv_i [4],
    output logic span_10v_o,
    output logic hold_o
);
    typedef enum logic [0:0] {
        SSCC_IDLE = 1'b0,
        SSCC_CONV = 1'b1
    } sscc_state_e;

    sscc_state_e state;
    logic trig_d;
    logic [7:0] cnt;
    logic signed [15:0] held [4];
    logic [15:0] out_reg [4];
    logic span_r;
    logic ref_r;

    // =========================================
    // Configuration
    always_ff @(posedge ref_clk_i) begin
        span_r <= link.span_sel;
        span_10v_o <= link.span_sel;
        if (sys_rst_i) begin
            ref_r <= 1'b0;
        end else begin
            ref_r <= link.ref_sel;
        end
    end
    assign link.ref_int_en = ref_r;

    // =========================================
    // Conversion sequence
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i || link.dev_reset) begin
            state <= SSCC_IDLE;
            trig_d <= 1'b0;
            cnt <= 8'h00;
            hold_o <= 1'b0;
            link.busy <= 1'b0;
        end else begin
            trig_d <= link.conversion_trigger;
            case (state)
                SSCC_IDLE: begin
                    if (link.conversion_trigger && !trig_d) begin
                        state <= SSCC_CONV;
                        hold_o <= 1'b1;
                        link.busy <= 1'b1;
                        cnt <= 8'(sscc_pkg::CONV_CYCLES - 1);
                    end
                end
                SSCC_CONV: begin
                    if (cnt == 8'h00) begin
                        state <= SSCC_IDLE;
                        hold_o <= 1'b0;
                        link.busy <= 1'b0;
                    end else begin
                        cnt <= cnt - 8'h01;
                    end
                end
                default: state <= SSCC_IDLE;
            endcase
        end
    end

    // Step: full span / 65536 -> code = mv * 65536 / (2*span), rounded half-step
    function automatic logic [15:0] to_code(input logic signed [15:0] mv, input logic s10);
        logic signed [31:0] num;
        logic signed [31:0] q;
        logic signed [31:0] half;
        num = 32'(mv) * 32'sd32768;
        // Division truncates toward zero, so the half step follows the sign
        half = s10 ? 32'sd5000 : 32'sd2500;
        if (num < 32'sd0) half = -half;
        q = (num + half) / (s10 ? 32'sd10000 : 32'sd5000);
        if (q > 32'sd32767) q = 32'sd32767;
        if (q < -32'sd32768) q = -32'sd32768;
        return q[15:0];
    endfunction

    // =========================================
    // Sampling and output register
    always_ff @(posedge ref_clk_i) begin
        for (int i = 0; i < sscc_pkg::CHANNELS; i++) begin
            if (sys_rst_i) begin
                held[i] <= 16'sh0000;
                out_reg[i] <= 16'h0000;
            end else begin
                if (state == SSCC_IDLE && link.conversion_trigger && !trig_d) begin
                    held[i] <= ain_mv_i[i];
                end
                if (state == SSCC_CONV && cnt == 8'h00) begin
                    out_reg[i] <= to_code(held[i], span_r);
                end
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            link.result <= 16'h0000;
        end else begin
            link.result <= out_reg[link.ch_sel];
        end
    end
endmodule // sscc_device

/* hdl/sscc_host.sv */
// Host end: register port, trigger, reset pulse, settle timing, readback.
// Assumes software uses the plain strobe port below.
//
// The implementer's own choices: the register offsets and strobed register access.
`timescale 1ns/10ps
module sscc_host (
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    sscc_if.host link,
    input wire logic [3:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    output logic irq_o
);
    logic [3:0] ctrl;
    logic [1:0] irq_stat;
    logic [1:0] irq_mask;
    logic busy_d;
    logic [15:0] settle;
    logic [2:0] rst_cnt;
    logic [15:0] res [4];
    logic [1:0] rd_ch;
    logic busy_fall;
    logic settle_done;
    logic [2:0] fill;
    logic fill_done;

    assign busy_fall = busy_d && !link.busy;
    assign fill_done = (fill == 3'h1);
    assign settle_done = (settle == 16'h0001);

    // =========================================
    // Control and pins
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            ctrl <= 4'h0;
            link.conversion_trigger <= 1'b0;
            link.span_sel <= 1'b0;
            link.ref_sel <= 1'b0;
            settle <= 16'h0000;
        end else begin
            link.conversion_trigger <= wr_i && addr_i == sscc_pkg::ADDR_CTRL
                && wdata_i[sscc_pkg::CTRL_START] && settle == 16'h0000 && !link.busy;
            if (wr_i && addr_i == sscc_pkg::ADDR_CTRL) begin
                ctrl <= wdata_i[3:0];
                link.span_sel <= wdata_i[sscc_pkg::CTRL_SPAN];
                link.ref_sel <= wdata_i[sscc_pkg::CTRL_REFSEL];
                if (wdata_i[sscc_pkg::CTRL_SPAN] != link.span_sel) begin
                    settle <= 16'(sscc_pkg::SETTLE_CYCLES);
                end
            end else if (settle != 16'h0000) begin
                settle <= settle - 16'h0001;
            end
        end
    end

    // Reset pulse to the device at power-up and on request
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            rst_cnt <= 3'(sscc_pkg::RESET_PULSE_CYCLES);
            link.dev_reset <= 1'b1;
        end else if (wr_i && addr_i == sscc_pkg::ADDR_CTRL && wdata_i[sscc_pkg::CTRL_RESET]) begin
            rst_cnt <= 3'(sscc_pkg::RESET_PULSE_CYCLES);
            link.dev_reset <= 1'b1;
        end else if (rst_cnt != 3'h0) begin
            rst_cnt <= rst_cnt - 3'h1;
            link.dev_reset <= (rst_cnt != 3'h1);
        end else begin
            link.dev_reset <= 1'b0;
        end
    end

    // =========================================
    // Readback of all channels after busy falls
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            busy_d <= 1'b0;
            rd_ch <= 2'h0;
            link.ch_sel <= 2'h0;
            for (int i = 0; i < sscc_pkg::CHANNELS; i++) res[i] <= 16'h0000;
        end else begin
            busy_d <= link.busy;
            link.ch_sel <= link.ch_sel + 2'h1;
            rd_ch <= link.ch_sel;
            // Result lags busy by one cycle: skip the stale first sample
            if (!link.busy && !busy_d) begin
                res[rd_ch] <= link.result;
            end
        end
    end

    // Done only after every channel has rotated past once
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            fill <= 3'h0;
        end else if (busy_fall) begin
            fill <= 3'(sscc_pkg::CHANNELS + 1);
        end else if (fill != 3'h0) begin
            fill <= fill - 3'h1;
        end
    end

    // =========================================
    // Interrupts and read port
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            irq_stat <= 2'h0;
            irq_mask <= 2'h0;
            irq_o <= 1'b0;
            rdata_o <= 32'h0000_0000;
        end else begin
            for (int b = 0; b < sscc_pkg::IRQ_BITS; b++) begin
                if ((b == sscc_pkg::IRQ_DONE && fill_done) ||
                    (b == sscc_pkg::IRQ_SETTLED && settle_done)) begin
                    irq_stat[b] <= 1'b1;
                end else if (wr_i && addr_i == sscc_pkg::ADDR_IRQ_STAT && wdata_i[b]) begin
                    irq_stat[b] <= 1'b0;
                end
            end
            if (wr_i && addr_i == sscc_pkg::ADDR_IRQ_MASK) irq_mask <= wdata_i[1:0];
            irq_o <= |(irq_stat & irq_mask);
            rdata_o <= 32'h0000_0000;
            if (rd_i) begin
                case (addr_i)
                    sscc_pkg::ADDR_CTRL: rdata_o <= {28'h0, ctrl};
                    sscc_pkg::ADDR_STATUS: rdata_o <= {28'h0, link.ref_int_en,
                        settle != 16'h0000, link.dev_reset,
                        link.busy || busy_d || fill != 3'h0};
                    sscc_pkg::ADDR_IRQ_STAT: rdata_o <= {30'h0, irq_stat};
                    sscc_pkg::ADDR_IRQ_MASK: rdata_o <= {30'h0, irq_mask};
                    4'h4, 4'h5, 4'h6, 4'h7: rdata_o <= {16'h0, res[addr_i[1:0]]};
                    default: rdata_o <= 32'h0000_0000;
                endcase
            end
        end
    end
endmodule // sscc_host

/* include/sscc_if.sv */
// Pin-level link between the converter control and its host.
// Assumes both ends share ref_clk_i.
`timescale 1ns/10ps
interface sscc_if;
    logic conversion_trigger;
    logic span_sel;
    logic ref_sel;
    logic dev_reset;
    logic busy;
    logic ref_int_en;
    logic [1:0] ch_sel;
    logic [15:0] result;
    modport device (input conversion_trigger, span_sel, ref_sel, dev_reset, ch_sel,
        output busy, ref_int_en, result);
    modport host (output conversion_trigger, span_sel, ref_sel, dev_reset, ch_sel,
        input busy, ref_int_en, result);
endinterface

/* include/sscc_pkg.sv */
// Constants shared by the conversion-control device end and the host end.
// Assumes a single 50 MHz clock and a synchronous active-high reset.
package sscc_pkg;
    localparam int CLK_MHZ = 50;
    localparam int CONV_TIME_NS = 2000;
    localparam int CONV_CYCLES = (CONV_TIME_NS * CLK_MHZ) / 1000;
    localparam int SETTLE_TIME_US = 80;
    localparam int SETTLE_CYCLES = SETTLE_TIME_US * CLK_MHZ;
    localparam int CHANNELS = 4;
    localparam int RES_BITS = 16;
    localparam int CODE_STEPS = 65536;
    localparam int SPAN_10V_MV = 10000;
    localparam int SPAN_5V_MV = 5000;
    localparam int INT_REF_MV = 2500;
    localparam int RESET_PULSE_CYCLES = 4;
    // Host register addresses
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h1;
    localparam logic [3:0] ADDR_IRQ_STAT = 4'h2;
    localparam logic [3:0] ADDR_IRQ_MASK = 4'h3;
    localparam logic [3:0] ADDR_RES0 = 4'h4;
    // Control bit positions
    localparam int CTRL_START = 0;
    localparam int CTRL_SPAN = 1;
    localparam int CTRL_REFSEL = 2;
    localparam int CTRL_RESET = 3;
    // Interrupt bits
    localparam int IRQ_DONE = 0;
    localparam int IRQ_SETTLED = 1;
    localparam int IRQ_BITS = 2;
endpackage

/* test/simultaneous_sampling_conversion_control_tb.sv */
// Testbench: host and device ends joined by the link.
// Assumes the package and interface are compiled first.
`timescale 1ns/10ps
module simultaneous_sampling_conversion_control_tb;
    logic ref_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [3:0] addr_i = 4'h0;
    logic [31:0] wdata_i = 32'h0;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [31:0] rdata_o, rv;
    logic irq_o, span_10v_o, hold_o, hv, iv, sv;
    logic signed [15:0] ain_mv_i [4];
    logic [63:0] prev = 64'h0;
    int errors = 0;
    int tests_run = 0;
    sscc_if link ();
    sscc_device sscc_device_i (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .link(link),
        .ain_mv_i(ain_mv_i), .span_10v_o(span_10v_o), .hold_o(hold_o));
    sscc_host sscc_host_i (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .link(link),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .irq_o(irq_o));
    sscc_monitor sscc_monitor_i (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
        .conversion_trigger(link.conversion_trigger), .ref_sel(link.ref_sel),
        .busy(link.busy), .ref_int_en(link.ref_int_en), .ch_sel(link.ch_sel),
        .result(link.result));
    always #10 ref_clk_i = ~ref_clk_i;
    // ====================================
    // Access tasks
    task automatic print_verdict();
        $display("errors %0d tests_run %0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        tests_run++;
        if (g !== e) begin
            errors++;
            $display("BAD %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge ref_clk_i);
        wr_i <= 1'b0;
        @(posedge ref_clk_i);
    endtask
    task automatic rd(input logic [3:0] a);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge ref_clk_i);
        rd_i <= 1'b0;
        @(negedge ref_clk_i);
        rv = rdata_o;
        hv = hold_o;
        iv = irq_o;
        sv = span_10v_o;
        @(posedge ref_clk_i);
    endtask
    task automatic wst(input int b, input logic v, input int n);
        for (int i = 0; i < n; i++) begin
            rd(sscc_pkg::ADDR_STATUS);
            if (rv[b] === v) break;
        end
        chk({15'h0, rv[b]}, {15'h0, v});
    endtask
    task automatic conv(input logic [31:0] c, input logic [63:0] e, input logic m);
        wr(sscc_pkg::ADDR_CTRL, c);
        wst(0, 1'b1, 5);
        chk({15'h0, hv}, 16'h1);
        for (int i = 0; i < 4; i++) ain_mv_i[i] <= 16'sh0123;
        rd(sscc_pkg::ADDR_RES0);
        chk(rv[15:0], prev[15:0]);
        wst(0, 1'b0, 60);
        for (int i = 0; i < 4; i++) begin
            rd(sscc_pkg::ADDR_RES0 + 4'(i));
            chk(rv[15:0], e[16*i+:16]);
        end
        chk({15'h0, hv}, 16'h0);
        prev = e;
        rd(sscc_pkg::ADDR_IRQ_STAT);
        chk({14'h0, iv, rv[0]}, {14'h0, m, 1'b1});
        wr(sscc_pkg::ADDR_IRQ_STAT, 32'h1);
        rd(sscc_pkg::ADDR_IRQ_STAT);
        chk({14'h0, iv, rv[0]}, 16'h0);
    endtask
    // ====================================
    // Sequence
    initial begin
        for (int k = 0; k < 4; k++) ain_mv_i[k] = 16'sh0;
        repeat (10) @(posedge ref_clk_i);
        sys_rst_i <= 1'b0;
        wst(1, 1'b0, 50);
        wr(sscc_pkg::ADDR_IRQ_MASK, 32'h1);
        wr(sscc_pkg::ADDR_CTRL, 32'h6);
        wst(2, 1'b0, 2100);
        chk({14'h0, sv, rv[3]}, 16'h3);
        ain_mv_i <= '{16'sd2500, -16'sd10000, 16'sd0, 16'sd10000};
        conv(32'h7, {16'h7FFF, 16'h0000, 16'h8000, 16'h2000}, 1'b1);
        wr(sscc_pkg::ADDR_IRQ_MASK, 32'h0);
        wr(sscc_pkg::ADDR_CTRL, 32'h0);
        wr(sscc_pkg::ADDR_CTRL, 32'h1);
        wst(0, 1'b0, 1);
        wst(2, 1'b0, 2100);
        chk({14'h0, sv, rv[3]}, 16'h0);
        ain_mv_i <= '{16'sd1250, -16'sd1, 16'sd5000, -16'sd2500};
        conv(32'h1, {16'hC000, 16'h7FFF, 16'hFFF9, 16'h2000}, 1'b0);
        print_verdict();
    end
    initial begin
        repeat (20000) @(posedge ref_clk_i);
        errors++;
        print_verdict();
    end
endmodule // simultaneous_sampling_conversion_control_tb

/* test/sscc_monitor.sv */
// Checker on the link between the host end and the device end.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/10ps
module sscc_monitor (
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    input wire logic conversion_trigger,
    input wire logic ref_sel,
    input wire logic busy,
    input wire logic ref_int_en,
    input wire logic [1:0] ch_sel,
    input wire logic [15:0] result
);
    int busy_cnt;
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            busy_cnt <= 0;
        end else begin
            busy_cnt <= busy ? busy_cnt + 1 : 0;
        end
    end
    // ====================================
    // Link timing
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i);
    AST_BUSY_START: assert property ($rose(conversion_trigger) && !busy |=> busy)
        else $error("busy did not follow trigger");
    AST_BUSY_CAUSE: assert property ($rose(busy) |-> $past(conversion_trigger))
        else $error("busy rose without trigger");
    AST_BUSY_LEN: assert property ($fell(busy) |-> busy_cnt == sscc_pkg::CONV_CYCLES)
        else $error("conversion length wrong");
    AST_BUSY_MAX: assert property (busy_cnt <= sscc_pkg::CONV_CYCLES)
        else $error("busy too long");
    AST_RESULT_HOLD: assert property (busy && busy_cnt >= 4 && ch_sel == $past(ch_sel, 4)
        |=> result == $past(result, 4))
        else $error("result changed during conversion");
    AST_REF_MODE: assert property (!$past(sys_rst_i) && $stable(ref_sel) |-> ref_int_en == ref_sel)
        else $error("reference mode does not follow select");
    AST_HOST_ORDER: assert property (busy |-> !$rose(conversion_trigger))
        else $error("trigger issued while busy");
    AST_TRIG_PULSE: assert property ($rose(conversion_trigger) |=> !conversion_trigger)
        else $error("trigger longer than one cycle");
endmodule // sscc_monitor
